/* iam_pkg.sv */
// Constants for the bus status and slave address mask block
package iam_pkg;
    // ------------------------------------------------------------
    // Register byte offsets (Avalon-MM, one word each)
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_STATUS = 6'h00;
    localparam logic [5:0] OFS_MASK   = 6'h04;
    localparam logic [5:0] OFS_CTRL   = 6'h08;
    localparam logic [5:0] OFS_OWN    = 6'h0c;
    localparam logic [5:0] OFS_RCV    = 6'h10;
    localparam logic [5:0] OFS_TRN    = 6'h14;
    localparam logic [5:0] OFS_IST    = 6'h18;
    localparam logic [5:0] OFS_ICLR   = 6'h1c;
    localparam logic [5:0] OFS_IEN    = 6'h20;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int IRQ_W  = 5;
    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int ST_TEN   = 8;
    localparam int ST_STOP  = 4;
    localparam int ST_START = 3;
    localparam int ST_DIR   = 2;
    localparam int ST_RBF   = 1;
    localparam int ST_TBF   = 0;
    // Control bit position
    localparam int CTRL_WIDE = 0;
    // ------------------------------------------------------------
    // Interrupt bit positions
    // ------------------------------------------------------------
    localparam int IRQ_START = 0;
    localparam int IRQ_STOP  = 1;
    localparam int IRQ_RX    = 2;
    localparam int IRQ_TX    = 3;
    localparam int IRQ_HIT   = 4;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] RST_MASK = 10'h000;
    localparam logic [ADDR_W-1:0] RST_OWN  = 10'h000;
    localparam logic [IRQ_W-1:0]  RST_IEN  = 5'h00;
endpackage

/* iam_top.sv */
// Bus status flags, address mask compare and register slave
// ------------------------------------------------------------
// Overview of operation
// - Ten-bit match flag sets on matching second address byte in ten-bit mode, clears on Stop.
// - Stop-seen flag is 1 when the latest bus condition was Stop.
// - Start-seen flag is 1 after Start or Repeated Start, 0 after Stop.
// - Direction flag takes 1 for read, 0 for write after first address byte.
// - Direction flag changes only on an address byte, holds during data.
// - Receive-full sets when a byte is stored, clears on software read.
// - Transmit-full sets on software write, clears when transmission ends.
// - Ten-bit mode: set mask bit excludes same address bit from compare.
// - Seven-bit mode: mask bit n excludes incoming address bit n+1.
// - Mask register has ten read/write bits, reset zero, upper bits zero.
// - Configuration bit selects ten-bit or seven-bit own address compare.
// ------------------------------------------------------------
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module iam_top
    import iam_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    // Avalon-MM slave
    input  wire logic [5:0]        i_address,
    input  wire logic              i_read,
    input  wire logic              i_write,
    input  wire logic [31:0]       i_writedata,
    input  wire logic [3:0]        i_byteenable,
    output logic      [31:0]       o_readdata,
    output logic                   o_waitrequest,
    // Events from the bus engine
    input  wire logic              i_start_det,
    input  wire logic              i_stop_det,
    input  wire logic              i_addr_rx,
    input  wire logic              i_addr_second,
    input  wire logic              i_addr_rw,
    input  wire logic [ADDR_W-1:0] i_addr_in,
    input  wire logic              i_rx_byte,
    input  wire logic [7:0]        i_rx_data,
    input  wire logic              i_tx_done,
    // To the bus engine
    output logic                   o_addr_hit,
    output logic      [7:0]        o_tx_data,
    output logic                   o_tx_full,
    output logic                   o_dir,
    // Interrupt
    output logic                   o_irq
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_n;

    // Two-stage release of the reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // ------------------------------------------------------------
    // Bus slave handshake
    // ------------------------------------------------------------
    logic        ack_q;
    logic        ack_d;
    logic        wreq_q;
    logic        wreq_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        take_w;
    logic        take_r;
    logic [15:0] wm;
    logic [15:0] wv;
    logic [15:0] stat;

    // Strobes and lane masks
    assign take_w = i_write & ack_q;
    assign take_r = i_read & ack_q;
    assign wm     = {{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
    assign wv     = i_writedata[15:0];

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] msk_q, msk_d;
    logic [ADDR_W-1:0] own_q, own_d;
    logic              wide_q, wide_d;
    logic              ten_q, ten_d;
    logic              stop_q, stop_d;
    logic              start_q, start_d;
    logic              dir_q, dir_d;
    logic              rbf_q, rbf_d;
    logic              tbf_q, tbf_d;
    logic [7:0]        rcv_q, rcv_d;
    logic [7:0]        trn_q, trn_d;
    logic              hit_q, hit_d;
    logic [IRQ_W-1:0]  ist_q, ist_d;
    logic [IRQ_W-1:0]  ien_q, ien_d;
    logic              irq_q, irq_d;
    logic [IRQ_W-1:0]  ev;
    logic [IRQ_W-1:0]  clr;

    // Answer one cycle after the request, then release
    always_comb begin
        ack_d  = (i_read | i_write) & ~ack_q;
        wreq_d = ~ack_d;
        rdata_d = rdata_q;
        if (i_read && !ack_q) begin
            case (i_address)
                OFS_STATUS: rdata_d = {16'h0000, stat};
                OFS_MASK:   rdata_d = {22'h000000, msk_q};
                OFS_CTRL:   rdata_d = {31'h00000000, wide_q};
                OFS_OWN:    rdata_d = {22'h000000, own_q};
                OFS_RCV:    rdata_d = {24'h000000, rcv_q};
                OFS_TRN:    rdata_d = {24'h000000, trn_q};
                OFS_IST:    rdata_d = {27'h0000000, ist_q};
                OFS_IEN:    rdata_d = {27'h0000000, ien_q};
                default:    rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q   <= 1'b0;
            wreq_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q   <= ack_d;
            wreq_q  <= wreq_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Address compare, one stage per bit
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] ok10;
    logic [ADDR_W-1:0] ok7;
    logic              hit;

    for (genvar g = 0; g < ADDR_W; g++) begin : g_cmp
        assign ok10[g] = msk_q[g] | (i_addr_in[g] == own_q[g]);
        if (g < 7) begin : g_lo
            assign ok7[g] = msk_q[g] | (i_addr_in[g+1] == own_q[g]);
        end else begin : g_hi
            assign ok7[g] = 1'b1;
        end
    end
    assign hit = wide_q ? (&ok10) : (&ok7);

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_comb begin
        msk_d  = msk_q;
        own_d  = own_q;
        wide_d = wide_q;
        if (take_w && i_address == OFS_MASK) begin
            msk_d = (msk_q & ~wm[ADDR_W-1:0]) | (wv[ADDR_W-1:0] & wm[ADDR_W-1:0]);
        end
        if (take_w && i_address == OFS_OWN) begin
            own_d = (own_q & ~wm[ADDR_W-1:0]) | (wv[ADDR_W-1:0] & wm[ADDR_W-1:0]);
        end
        if (take_w && i_address == OFS_CTRL && i_byteenable[0]) begin
            wide_d = wv[CTRL_WIDE];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            msk_q  <= RST_MASK;
            own_q  <= RST_OWN;
            wide_q <= 1'b0;
        end else begin
            msk_q  <= msk_d;
            own_q  <= own_d;
            wide_q <= wide_d;
        end
    end

    // ------------------------------------------------------------
    // Status flags and holding registers
    // ------------------------------------------------------------
    // Status word; writes to it are not decoded at all
    always_comb begin
        stat           = 16'h0000;
        stat[ST_TEN]   = ten_q;
        stat[ST_STOP]  = stop_q;
        stat[ST_START] = start_q;
        stat[ST_DIR]   = dir_q;
        stat[ST_RBF]   = rbf_q;
        stat[ST_TBF]   = tbf_q;
    end

    // Flag updates; a set wins over a same-cycle clear, except that Stop wins over Start
    always_comb begin
        ten_d   = ten_q;
        stop_d  = stop_q;
        start_d = start_q;
        dir_d   = dir_q;
        rbf_d   = rbf_q;
        tbf_d   = tbf_q;
        rcv_d   = rcv_q;
        trn_d   = trn_q;
        hit_d   = i_addr_rx & hit;
        if (i_stop_det) begin
            ten_d = 1'b0;
        end
        if (i_addr_rx && i_addr_second && wide_q && hit) begin
            ten_d = 1'b1;
        end
        if (i_stop_det) begin
            stop_d  = 1'b1;
            start_d = 1'b0;
        end else if (i_start_det) begin
            stop_d  = 1'b0;
            start_d = 1'b1;
        end
        if (i_addr_rx && !i_addr_second) begin
            dir_d = i_addr_rw;
        end
        if (take_r && i_address == OFS_RCV) begin
            rbf_d = 1'b0;
        end
        if (i_rx_byte) begin
            rbf_d = 1'b1;
            rcv_d = i_rx_data;
        end
        if (i_tx_done) begin
            tbf_d = 1'b0;
        end
        if (take_w && i_address == OFS_TRN && i_byteenable[0]) begin
            tbf_d = 1'b1;
            trn_d = wv[7:0];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ten_q   <= 1'b0;
            stop_q  <= 1'b0;
            start_q <= 1'b0;
            dir_q   <= 1'b0;
            rbf_q   <= 1'b0;
            tbf_q   <= 1'b0;
            rcv_q   <= 8'h00;
            trn_q   <= 8'h00;
            hit_q   <= 1'b0;
        end else begin
            ten_q   <= ten_d;
            stop_q  <= stop_d;
            start_q <= start_d;
            dir_q   <= dir_d;
            rbf_q   <= rbf_d;
            tbf_q   <= tbf_d;
            rcv_q   <= rcv_d;
            trn_q   <= trn_d;
            hit_q   <= hit_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, clear and enable
    // ------------------------------------------------------------
    always_comb begin
        ev            = '0;
        ev[IRQ_START] = i_start_det;
        ev[IRQ_STOP]  = i_stop_det;
        ev[IRQ_RX]    = i_rx_byte;
        ev[IRQ_TX]    = i_tx_done;
        ev[IRQ_HIT]   = i_addr_rx & hit;
        clr           = '0;
        if (take_w && i_address == OFS_ICLR) begin
            clr = wv[IRQ_W-1:0] & wm[IRQ_W-1:0];
        end
        ien_d = ien_q;
        if (take_w && i_address == OFS_IEN) begin
            ien_d = (ien_q & ~wm[IRQ_W-1:0]) | (wv[IRQ_W-1:0] & wm[IRQ_W-1:0]);
        end
        ist_d = (ist_q & ~clr) | ev;
        irq_d = |(ist_q & ien_q);
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ist_q <= '0;
            ien_q <= RST_IEN;
            irq_q <= 1'b0;
        end else begin
            ist_q <= ist_d;
            ien_q <= ien_d;
            irq_q <= irq_d;
        end
    end

    // Outputs straight from flops
    assign o_readdata    = rdata_q;
    assign o_waitrequest = wreq_q;
    assign o_addr_hit    = hit_q;
    assign o_tx_data     = trn_q;
    assign o_tx_full     = tbf_q;
    assign o_dir         = dir_q;
    assign o_irq         = irq_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_rd_mask;
        i_read && !ack_q && i_address == OFS_MASK;
    endsequence
    sequence s_tx_wr;
        take_w && i_address == OFS_TRN && i_byteenable[0];
    endsequence

    property p_ten_set;
        @(posedge i_clk) disable iff (!rst_n)
        i_addr_rx && i_addr_second && wide_q && (((i_addr_in ^ own_q) & ~msk_q) == 10'h000)
        |=> ten_q;
    endproperty
    a_ten_set: assert property (p_ten_set) else $error("ten-bit flag not set");

    property p_ten_clr;
        @(posedge i_clk) disable iff (!rst_n)
        i_stop_det && !i_addr_rx ##1 !i_addr_rx [*2] |-> !ten_q;
    endproperty
    a_ten_clr: assert property (p_ten_clr) else $error("ten-bit flag not cleared");

    property p_stop;
        @(posedge i_clk) disable iff (!rst_n)
        i_stop_det |=> stop_q && !start_q;
    endproperty
    a_stop: assert property (p_stop) else $error("stop flag wrong");

    property p_start;
        @(posedge i_clk) disable iff (!rst_n)
        i_start_det && !i_stop_det |=> start_q && !stop_q;
    endproperty
    a_start: assert property (p_start) else $error("start flag wrong");

    property p_dir;
        @(posedge i_clk) disable iff (!rst_n)
        i_addr_rx && !i_addr_second |=> o_dir == $past(i_addr_rw);
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");

    property p_dir_hold;
        @(posedge i_clk) disable iff (!rst_n)
        !(i_addr_rx && !i_addr_second) |=> $stable(o_dir);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("direction moved");

    property p_rbf;
        @(posedge i_clk) disable iff (!rst_n)
        i_rx_byte |=> rbf_q && rcv_q == $past(i_rx_data);
    endproperty
    a_rbf: assert property (p_rbf) else $error("receive flag not set");

    property p_tbf;
        @(posedge i_clk) disable iff (!rst_n)
        s_tx_wr |=> o_tx_full && o_tx_data == $past(i_writedata[7:0]);
    endproperty
    a_tbf: assert property (p_tbf) else $error("transmit flag not set");

    property p_hit10;
        @(posedge i_clk) disable iff (!rst_n)
        i_addr_rx && wide_q |=> o_addr_hit == $past(((i_addr_in ^ own_q) & ~msk_q) == 10'h000);
    endproperty
    a_hit10: assert property (p_hit10) else $error("ten-bit compare wrong");

    property p_hit7;
        @(posedge i_clk) disable iff (!rst_n)
        i_addr_rx && !wide_q
        |=> o_addr_hit == $past(((i_addr_in[7:1] ^ own_q[6:0]) & ~msk_q[6:0]) == 7'h00);
    endproperty
    a_hit7: assert property (p_hit7) else $error("seven-bit compare wrong");

    property p_msk_rd;
        @(posedge i_clk) disable iff (!rst_n)
        s_rd_mask |=> !o_waitrequest && o_readdata[31:10] == 22'h000000;
    endproperty
    a_msk_rd: assert property (p_msk_rd) else $error("mask upper bits not zero");

endmodule
`default_nettype wire

/* iam_bus_model.sv */
// Far-side bus engine model issuing bus condition and byte events
`timescale 1ns/1ps
`default_nettype none
module iam_bus_model
    import iam_pkg::*;
(
    // Clock
    input  wire logic              i_clk,
    // Events towards the block
    output var  logic              o_start_det,
    output var  logic              o_stop_det,
    output var  logic              o_addr_rx,
    output var  logic              o_addr_second,
    output var  logic              o_addr_rw,
    output var  logic [ADDR_W-1:0] o_addr_in,
    output var  logic              o_rx_byte,
    output var  logic [7:0]        o_rx_data,
    output var  logic              o_tx_done
);
    // Quiet bus at time zero
    initial begin
        {o_start_det, o_stop_det, o_addr_rx, o_addr_second, o_addr_rw, o_rx_byte, o_tx_done} = 7'h00;
        o_addr_in = 10'h155;
        o_rx_data = 8'h55;
    end
    // End a pulse; stale data is scrambled so it cannot pass for valid
    task automatic finish_pulse();
        @(posedge i_clk);
        {o_start_det, o_stop_det, o_addr_rx, o_addr_second, o_rx_byte, o_tx_done} <= 6'h00;
        o_addr_rw <= ~o_addr_rw;
        o_addr_in <= ~o_addr_in;
        o_rx_data <= ~o_rx_data;
    endtask
    // Start, repeated start or stop seen on the wire
    task automatic cond(input logic is_stop);
        @(posedge i_clk);
        o_start_det <= ~is_stop;
        o_stop_det  <= is_stop;
        finish_pulse();
    endtask
    // Address byte received
    task automatic addr(input logic second, input logic rw, input logic [ADDR_W-1:0] a);
        @(posedge i_clk);
        o_addr_rx     <= 1'b1;
        o_addr_second <= second;
        o_addr_rw     <= rw;
        o_addr_in     <= a;
        finish_pulse();
    endtask
    // Data byte received
    task automatic rx(input logic [7:0] d);
        @(posedge i_clk);
        o_rx_byte <= 1'b1;
        o_rx_data <= d;
        finish_pulse();
    endtask
    // Held byte fully sent
    task automatic txd();
        @(posedge i_clk);
        o_tx_done <= 1'b1;
        finish_pulse();
    endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the bus status and address mask block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import iam_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic              i_clk, i_rst_b, i_read, i_write;
    logic [5:0]        i_address;
    logic [31:0]       i_writedata, o_readdata;
    logic              o_waitrequest, o_addr_hit, o_tx_full, o_dir, o_irq;
    logic [7:0]        o_tx_data, rx_data;
    logic              start_det, stop_det, addr_rx, addr_second, addr_rw, rx_byte, tx_done;
    logic [ADDR_W-1:0] addr_in;
    logic [3:0]        byteenable;
    int                num_errors, compares;
    // Design and far-side model
    iam_top iam_top_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(byteenable), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_start_det(start_det), .i_stop_det(stop_det),
        .i_addr_rx(addr_rx), .i_addr_second(addr_second), .i_addr_rw(addr_rw), .i_addr_in(addr_in),
        .i_rx_byte(rx_byte), .i_rx_data(rx_data), .i_tx_done(tx_done), .o_addr_hit(o_addr_hit),
        .o_tx_data(o_tx_data), .o_tx_full(o_tx_full), .o_dir(o_dir), .o_irq(o_irq));
    iam_bus_model iam_bus_model_i (.i_clk(i_clk), .o_start_det(start_det), .o_stop_det(stop_det),
        .o_addr_rx(addr_rx), .o_addr_second(addr_second), .o_addr_rw(addr_rw), .o_addr_in(addr_in),
        .o_rx_byte(rx_byte), .o_rx_data(rx_data), .o_tx_done(tx_done));
    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] be, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge i_clk);
        i_address   <= a;
        byteenable  <= be;
        i_write     <= wr;
        i_read      <= ~wr;
        i_writedata <= d;
        for (n = 0; n < 16; n++) begin
            @(posedge i_clk);
            if (o_waitrequest === 1'b0) break;
        end
        q = o_readdata;
        i_read  <= 1'b0;
        i_write <= 1'b0;
        if (n == 16) begin
            check("waitrequest", 32'h0, 32'h1);
            close_out();
        end
    endtask
    task automatic wr_be(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, be, a, d, q);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        wr_be(a, d, 4'hf);
    endtask
    task automatic rd_chk(input string name, input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, 4'hf, a, 32'h0, q);
        check(name, exp, q);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd_chk("mask reset", OFS_MASK, 32'h0);
        rd_chk("status reset", OFS_STATUS, 32'h0);
        wr(OFS_MASK, 32'hffff_ffff);
        rd_chk("mask width", OFS_MASK, 32'h3ff);
        wr(OFS_MASK, 32'h0000_0155);
        rd_chk("mask value", OFS_MASK, 32'h155);
        wr_be(OFS_MASK, 32'h0000_02aa, 4'h2);
        rd_chk("mask upper lane", OFS_MASK, 32'h255);
        wr_be(OFS_MASK, 32'h0000_00aa, 4'h1);
        rd_chk("mask lower lane", OFS_MASK, 32'h2aa);
        rd_chk("unmapped", 6'h3c, 32'h0);
    endtask
    task automatic t_conditions();
        iam_bus_model_i.cond(1'b0);
        rd_chk("after start", OFS_STATUS, 32'h8);
        iam_bus_model_i.cond(1'b1);
        rd_chk("after stop", OFS_STATUS, 32'h10);
        iam_bus_model_i.cond(1'b0);
        rd_chk("after restart", OFS_STATUS, 32'h8);
        iam_bus_model_i.cond(1'b1);
    endtask
    task automatic t_seven_bit();
        wr(OFS_CTRL, 32'h0);
        wr(OFS_OWN, 32'h055);
        wr(OFS_MASK, 32'h001);
        for (int i = 0; i < 2; i++) begin
            iam_bus_model_i.addr(1'b0, 1'b1, 10'h0aa ^ (10'h002 << i));
            #1;
            check("seven bit hit", {31'h0, i == 0}, {31'h0, o_addr_hit});
        end
        check("dir read", 32'h1, {31'h0, o_dir});
        iam_bus_model_i.rx(8'h3c);
        iam_bus_model_i.addr(1'b1, 1'b0, 10'h0aa);
        #1;
        check("dir held", 32'h1, {31'h0, o_dir});
        rd_chk("rcv data", OFS_RCV, 32'h3c);
        iam_bus_model_i.addr(1'b0, 1'b0, 10'h0aa);
        #1;
        check("dir write", 32'h0, {31'h0, o_dir});
    endtask
    task automatic t_ten_bit();
        wr(OFS_CTRL, 32'h1);
        wr(OFS_OWN, 32'h2f5);
        wr(OFS_MASK, 32'h004);
        iam_bus_model_i.cond(1'b0);
        iam_bus_model_i.addr(1'b0, 1'b0, 10'h2f5);
        rd_chk("first byte only", OFS_STATUS, 32'h8);
        iam_bus_model_i.addr(1'b1, 1'b0, 10'h2f1);
        #1;
        check("ten bit hit", 32'h1, {31'h0, o_addr_hit});
        rd_chk("ten bit set", OFS_STATUS, 32'h108);
        iam_bus_model_i.addr(1'b1, 1'b0, 10'h2f7);
        #1;
        check("ten bit miss", 32'h0, {31'h0, o_addr_hit});
        iam_bus_model_i.cond(1'b1);
        rd_chk("ten bit cleared", OFS_STATUS, 32'h10);
        iam_bus_model_i.cond(1'b0);
        iam_bus_model_i.addr(1'b1, 1'b0, 10'h2f7);
        rd_chk("ten bit no match", OFS_STATUS, 32'h8);
        iam_bus_model_i.cond(1'b1);
    endtask
    task automatic t_buffers();
        iam_bus_model_i.rx(8'h96);
        rd_chk("rx full set", OFS_STATUS, 32'h12);
        rd_chk("rcv read", OFS_RCV, 32'h96);
        rd_chk("rx full clear", OFS_STATUS, 32'h10);
        wr(OFS_TRN, 32'h5a);
        #1;
        check("tx full set", 32'h1, {31'h0, o_tx_full});
        check("tx data", 32'h5a, {24'h0, o_tx_data});
        wr(OFS_STATUS, 32'hffff);
        rd_chk("status write ignored", OFS_STATUS, 32'h11);
        iam_bus_model_i.txd();
        #1;
        check("tx full clear", 32'h0, {31'h0, o_tx_full});
        wr_be(OFS_TRN, 32'h77, 4'h2);
        #1;
        check("tx lane off", 32'h0, {31'h0, o_tx_full});
    endtask
    task automatic t_irq();
        iam_bus_model_i.rx(8'h11);
        @(posedge i_clk);
        #1;
        check("irq masked", 32'h0, {31'h0, o_irq});
        wr(OFS_IEN, 32'h04);
        @(posedge i_clk);
        #1;
        check("irq raised", 32'h1, {31'h0, o_irq});
        rd_chk("ien value", OFS_IEN, 32'h04);
        rd_chk("ist value", OFS_IST, 32'h1f);
        wr(OFS_ICLR, 32'h04);
        @(posedge i_clk);
        #1;
        check("irq cleared", 32'h0, {31'h0, o_irq});
        rd_chk("iclr reads zero", OFS_ICLR, 32'h0);
        rd_chk("rcv drain", OFS_RCV, 32'h11);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        i_clk       = 1'b0;
        i_rst_b     = 1'b0;
        i_read      = 1'b0;
        i_write     = 1'b0;
        i_address   = 6'h00;
        i_writedata = 32'h0;
        byteenable  = 4'hf;
        num_errors  = 0;
        compares    = 0;
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clk);
        t_regs();
        t_conditions();
        t_seven_bit();
        t_ten_bit();
        t_buffers();
        t_irq();
        close_out();
    end
endmodule
`default_nettype wire
